// ===== tb/board_model.sv
// Board model: pull-ups and external drivers on the port pads.
// Assumes pads are packed as {port9, port8, port7, port6, port5}.
`default_nettype none
module board_model (
  // Device side
  input  wire logic [33:0] dev_out,
  input  wire logic [33:0] dev_oe,
  // Board drivers
  input  wire logic [33:0] ext_val,
  input  wire logic [33:0] ext_en,
  // Resolved pads
  output logic      [33:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Pad resolution
  // The board yields to the device, so nothing fights the write-inhibit pin.
  // A released line falls back to the pull-up rather than keeping its last value.
  always_comb pad = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | (~dev_oe & ~ext_en);
endmodule : board_model
`default_nettype wire

// ===== tb/tb_top.sv
// Bench for the port pin function select block.
// Assumes the board model resolves every pad.
`include "pin_mux_consts.svh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top
  import pin_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, resetn, avs_read, avs_write, avs_waitrequest, ws;
  logic [31:0] avs_address, avs_writedata, avs_readdata, rdata, q;
  logic [3:0]  avs_byteenable;
  logic        ext_read_strobe, pulse_gen_out_a, pulse_gen_out_b, ram_write_inhibit_req;
  logic [7:0]  compare_unit_outputs, analog_channel_low_group, analog_channel_high_group;
  logic [5:0]  reload_timer_outputs;
  logic [15:0] analog_select;
  logic [1:0]  port5_in, port5_out, port5_oe;
  byte_t       port6_in, port6_out, port6_oe, port7_in, port7_out, port7_oe;
  byte_t       port8_in, port8_out, port8_oe, port9_in, port9_out, port9_oe;
  logic [33:0] pad, ext_val, ext_en;
  int          bad_count, comparisons;
  assign {port9_in, port8_in, port7_in, port6_in, port5_in} = pad;
  port_pin_function_select uut (.*);
  board_model board (
    .dev_out ({port9_out, port8_out, port7_out, port6_out, port5_out}),
    .dev_oe  ({port9_oe, port8_oe, port7_oe, port6_oe, port5_oe}),
    .ext_val (ext_val),
    .ext_en  (ext_en),
    .pad     (pad)
  );
  // ==========================================
  // Clock, bus sampling and bus cycles
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Mid-cycle samples stand for what the master sees at the next rising edge.
  always @(negedge clk_sys) begin
    ws <= avs_waitrequest;
    rdata <= avs_readdata;
  end
  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Only the watchdog ends a wait whose answer never comes.
    do @(posedge clk_sys); while (ws !== 1'b0);
    rd = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic w(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : w
  task automatic settle;
    @(negedge clk_sys);
  endtask : settle
  // ==========================================
  // Scenarios
  task automatic t_reset;
    bus(1'b0, `OFS_ANALOG_EN, 32'h0, q);
    `CHK(q[15:0], `RST_ANALOG_EN)
    settle;
    `CHK(port6_oe, ~`RST_OD_DATA)
    `CHK(port9_oe, ~`RST_OD_DATA)
  endtask : t_reset
  task automatic t_port5;
    w(`OFS_P5_DIR, 32'h3);
    w(`OFS_P5_DATA, 32'h1);
    ext_read_strobe <= 1'b0;
    settle;
    `CHK(port5_out, 2'b01)
    `CHK(ram_write_inhibit_req, 1'b0)
    w(`OFS_MODE, 32'h1 << `MODE_EXTBUS_BIT);
    w(`OFS_P5_DATA, 32'h2);
    settle;
    `CHK(port5_out, 2'b10)
    `CHK(ram_write_inhibit_req, 1'b1)
    @(posedge clk_sys);
    ext_read_strobe <= 1'b1;
    settle;
    `CHK(port5_out[0], 1'b1)
    `CHK(port5_oe[0], 1'b1)
    w(`OFS_P5_DIR, 32'h1);
    ext_en[1] <= 1'b1;
    ext_val[1] <= 1'b0;
    settle;
    `CHK(ram_write_inhibit_req, 1'b0)
    w(`OFS_MODE, 32'h0);
    settle;
    `CHK(port5_out[0], 1'b0)
  endtask : t_port5
  task automatic t_analog;
    w(`OFS_P6_DATA, 32'h5a);
    w(`OFS_P9_DATA, 32'ha5);
    w(`OFS_ANALOG_EN, 32'h0ff0);
    ext_en[33:2] <= {8'hff, 16'h0, 8'hff};
    ext_val[33:2] <= {8'h3c, 16'h0, 8'h3c};
    settle;
    `CHK(port6_oe, 8'h05)
    `CHK(port6_out, 8'h00)
    `CHK(port9_oe, 8'h50)
    `CHK(port9_out, 8'h00)
    `CHK(analog_select, 16'h0ff0)
    `CHK(analog_channel_low_group, 8'h30)
    `CHK(analog_channel_high_group, 8'h0c)
  endtask : t_analog
  task automatic t_periph;
    w(`OFS_P7_DIR, 32'h00);
    w(`OFS_P7_DATA, 32'h0f);
    w(`OFS_P8_DIR, 32'h00);
    w(`OFS_P8_DATA, 32'h00);
    compare_unit_outputs <= 8'ha5;
    reload_timer_outputs <= 6'h3f;
    settle;
    `CHK(port7_out, 8'h0f)
    `CHK(port7_oe, 8'h00)
    w(`OFS_PERIPH_EN, 32'h1 << `PEN_COMPARE_BIT);
    settle;
    `CHK(port7_out, 8'ha5)
    `CHK(port7_oe, 8'hff)
    for (int k = 0; k < 6; k++) begin
      w(`OFS_PERIPH_EN, 32'h1 << (`PEN_TIMER_LSB + k));
      settle;
      `CHK(port8_out, 8'h01 << k)
      `CHK(port8_oe, 8'h01 << k)
    end
    w(`OFS_PERIPH_EN, 32'h1 << `PEN_PULSE_BIT);
    pulse_gen_out_a <= 1'b1;
    settle;
    `CHK(port8_out, 8'h40)
    `CHK(port8_oe, 8'hc0)
    @(posedge clk_sys);
    pulse_gen_out_a <= 1'b0;
    pulse_gen_out_b <= 1'b1;
    settle;
    `CHK(port8_out, 8'h80)
    bus(1'b0, 32'h30, 32'h0, q);
    `CHK(q, 32'h0)
  endtask : t_periph
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic final_report;
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {ext_read_strobe, pulse_gen_out_a, pulse_gen_out_b} = '0;
    {compare_unit_outputs, reload_timer_outputs, ext_val, ext_en} = '0;
    avs_byteenable = 4'hf;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_port5;
    t_analog;
    t_periph;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report;
  end
endmodule : tb_top
`default_nettype wire

// ===== verilog/pin_cell.sv
// One port pin driver cell: chooses peripheral or port data and drive mode.
// Assumes the pad resolves open drain from the enable signal.
`default_nettype none
module pin_cell (
  // Selection
  input  wire logic periph_sel,
  input  wire logic periph_val,
  // Port side
  input  wire logic port_val,
  input  wire logic port_dir,
  input  wire logic open_drain,
  // Pad
  output logic      pad_out,
  output logic      pad_oe
);
  logic val;
  assign val     = periph_sel ? periph_val : port_val;
  assign pad_out = open_drain ? 1'b0 : val;
  assign pad_oe  = periph_sel ? 1'b1 : (open_drain ? ~val : port_dir);
endmodule : pin_cell
`default_nettype wire

// ===== verilog/pin_mux_consts.svh
// Constants for the port pin function select block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
// ==========================================================
// Register offsets
`define OFS_MODE      32'h0000_0000
`define OFS_ANALOG_EN 32'h0000_0004
`define OFS_PERIPH_EN 32'h0000_0008
`define OFS_P5_DATA   32'h0000_000c
`define OFS_P5_DIR    32'h0000_0010
`define OFS_P6_DATA   32'h0000_0014
`define OFS_P7_DATA   32'h0000_0018
`define OFS_P7_DIR    32'h0000_001c
`define OFS_P8_DATA   32'h0000_0020
`define OFS_P8_DIR    32'h0000_0024
`define OFS_P9_DATA   32'h0000_0028
`define OFS_PIN_IN    32'h0000_002c
// ==========================================================
// Field positions and reset values
`define MODE_EXTBUS_BIT 0
`define PEN_COMPARE_BIT 0
`define PEN_TIMER_LSB   1
`define PEN_PULSE_BIT   7
`define RST_ANALOG_EN   16'h0000
`define RST_OD_DATA     8'hff
`endif

// ===== verilog/pin_mux_pkg.sv
// Types shared by the pin function select block.
// Assumes nothing beyond the compiler.
`default_nettype none
package pin_mux_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {bus_idle, bus_ack} bus_state_e;
endpackage : pin_mux_pkg
`default_nettype wire

// ===== verilog/port_pin_function_select.sv
// Top of the pin function select for ports five to nine.
// Assumes peripheral outputs and enables arrive synchronous to clk_sys.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`include "pin_mux_consts.svh"
`default_nettype none
module port_pin_function_select
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Peripheral sources
  input  wire logic        ext_read_strobe,
  input  wire logic [7:0]  compare_unit_outputs,
  input  wire logic [5:0]  reload_timer_outputs,
  input  wire logic        pulse_gen_out_a,
  input  wire logic        pulse_gen_out_b,
  // Peripheral sinks
  output logic             ram_write_inhibit_req,
  output logic [7:0]       analog_channel_low_group,
  output logic [7:0]       analog_channel_high_group,
  output logic [15:0]      analog_select,
  // Pads, ports five to nine
  input  wire logic [1:0]  port5_in,
  output logic      [1:0]  port5_out,
  output logic      [1:0]  port5_oe,
  input  wire logic [7:0]  port6_in,
  output logic      [7:0]  port6_out,
  output logic      [7:0]  port6_oe,
  input  wire logic [7:0]  port7_in,
  output logic      [7:0]  port7_out,
  output logic      [7:0]  port7_oe,
  input  wire logic [7:0]  port8_in,
  output logic      [7:0]  port8_out,
  output logic      [7:0]  port8_oe,
  input  wire logic [7:0]  port9_in,
  output logic      [7:0]  port9_out,
  output logic      [7:0]  port9_oe
);
  // ==========================================================
  // Registers
  // Software-visible state; the pads show it or, where it selects them, the peripheral outputs.
  logic        extbus_ff;
  logic [15:0] analog_en_ff;
  logic [8:0]  periph_en_ff;
  logic [1:0]  p5_data_ff;
  logic [1:0]  p5_dir_ff;
  byte_t       p6_data_ff;
  byte_t       p7_data_ff;
  byte_t       p7_dir_ff;
  byte_t       p8_data_ff;
  byte_t       p8_dir_ff;
  byte_t       p9_data_ff;
  bus_state_e  bus_ff;
  logic [31:0] rdata_ff;
  logic        wr_go;
  logic [31:0] wd;

  // ==========================================================
  // Bus handshake
  // One wait cycle per access keeps read data registered.
  assign avs_waitrequest = (avs_read | avs_write) & (bus_ff != bus_ack);
  assign wr_go = avs_write & (bus_ff == bus_ack);
  assign wd = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_ff <= bus_idle;
    end else begin
      case (bus_ff)
        bus_idle: bus_ff <= (avs_read | avs_write) ? bus_ack : bus_idle;
        bus_ack:  bus_ff <= bus_idle;
        default:  bus_ff <= bus_idle;
      endcase
    end
  end

  // ==========================================================
  // Register writes
  // Masked bytes land as zero, so a partial write clears the bytes it skips.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      extbus_ff    <= 1'b0;
      analog_en_ff <= `RST_ANALOG_EN;
      periph_en_ff <= 9'h000;
      p5_data_ff   <= 2'h0;
      p5_dir_ff    <= 2'h0;
      p6_data_ff   <= `RST_OD_DATA;
      p7_data_ff   <= 8'h00;
      p7_dir_ff    <= 8'h00;
      p8_data_ff   <= 8'h00;
      p8_dir_ff    <= 8'h00;
      p9_data_ff   <= `RST_OD_DATA;
    end else if (wr_go) begin
      case (avs_address)
        `OFS_MODE:      extbus_ff    <= wd[`MODE_EXTBUS_BIT];
        `OFS_ANALOG_EN: analog_en_ff <= wd[15:0];
        `OFS_PERIPH_EN: periph_en_ff <= wd[8:0];
        `OFS_P5_DATA:   p5_data_ff   <= wd[1:0];
        `OFS_P5_DIR:    p5_dir_ff    <= wd[1:0];
        `OFS_P6_DATA:   p6_data_ff   <= wd[7:0];
        `OFS_P7_DATA:   p7_data_ff   <= wd[7:0];
        `OFS_P7_DIR:    p7_dir_ff    <= wd[7:0];
        `OFS_P8_DATA:   p8_data_ff   <= wd[7:0];
        `OFS_P8_DIR:    p8_dir_ff    <= wd[7:0];
        `OFS_P9_DATA:   p9_data_ff   <= wd[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read data
  // Data is captured in the wait cycle and stands until the next read.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & (bus_ff == bus_idle)) begin
      case (avs_address)
        `OFS_MODE:      rdata_ff <= {31'h0, extbus_ff};
        `OFS_ANALOG_EN: rdata_ff <= {16'h0, analog_en_ff};
        `OFS_PERIPH_EN: rdata_ff <= {23'h0, periph_en_ff};
        `OFS_P5_DATA:   rdata_ff <= {30'h0, p5_data_ff};
        `OFS_P5_DIR:    rdata_ff <= {30'h0, p5_dir_ff};
        `OFS_P6_DATA:   rdata_ff <= {24'h0, p6_data_ff};
        `OFS_P7_DATA:   rdata_ff <= {24'h0, p7_data_ff};
        `OFS_P7_DIR:    rdata_ff <= {24'h0, p7_dir_ff};
        `OFS_P8_DATA:   rdata_ff <= {24'h0, p8_data_ff};
        `OFS_P8_DIR:    rdata_ff <= {24'h0, p8_dir_ff};
        `OFS_P9_DATA:   rdata_ff <= {24'h0, p9_data_ff};
        `OFS_PIN_IN:    rdata_ff <= {port9_in, port8_in, port7_in, port5_in, port6_in[5:0]};
        default:        rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // ==========================================================
  // Peripheral sinks
  // Bit7 of port five is sampled for the inhibit request but stays a drivable port; software must keep drivers off it.
  assign ram_write_inhibit_req     = port5_in[1];
  assign analog_select             = analog_en_ff;
  assign analog_channel_low_group  = port6_in & analog_en_ff[7:0];
  assign analog_channel_high_group = port9_in & analog_en_ff[15:8];

  // ==========================================================
  // Port five select
  // Bit7 has no peripheral output, so it stays a plain port in every mode.
  logic [1:0] p5_sel;
  logic [1:0] p5_val;
  assign p5_sel = {1'b0, extbus_ff};
  assign p5_val = {1'b0, ext_read_strobe};

  // ==========================================================
  // Port eight select
  // One enable serves both pulse pins; they cannot be handed over singly.
  logic [7:0] p8_sel;
  logic [7:0] p8_val;
  assign p8_sel = {{2{periph_en_ff[`PEN_PULSE_BIT]}}, periph_en_ff[`PEN_TIMER_LSB +: 6]};
  assign p8_val = {pulse_gen_out_b, pulse_gen_out_a, reload_timer_outputs};

  // ==========================================================
  // Open-drain ports six and nine
  // Analog pins never drive; the cell also forces open-drain outputs low and releases the pin for data ones.
  logic [7:0] p6_o;
  logic [7:0] p6_e;
  logic [7:0] p9_o;
  logic [7:0] p9_e;
  assign port6_out = p6_o;
  assign port6_oe  = p6_e & ~analog_en_ff[7:0];
  assign port9_out = p9_o;
  assign port9_oe  = p9_e & ~analog_en_ff[15:8];

  // ==========================================================
  // Pin cells
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi < 2) begin : g_p5
        pin_cell u_p5 (
          .periph_sel (p5_sel[gi]),
          .periph_val (p5_val[gi]),
          .port_val   (p5_data_ff[gi]),
          .port_dir   (p5_dir_ff[gi]),
          .open_drain (1'b0),
          .pad_out    (port5_out[gi]),
          .pad_oe     (port5_oe[gi])
        );
      end
      pin_cell u_p6 (
        .periph_sel (1'b0),
        .periph_val (1'b0),
        .port_val   (p6_data_ff[gi]),
        .port_dir   (1'b0),
        .open_drain (1'b1),
        .pad_out    (p6_o[gi]),
        .pad_oe     (p6_e[gi])
      );
      pin_cell u_p7 (
        .periph_sel (periph_en_ff[`PEN_COMPARE_BIT]),
        .periph_val (compare_unit_outputs[gi]),
        .port_val   (p7_data_ff[gi]),
        .port_dir   (p7_dir_ff[gi]),
        .open_drain (1'b0),
        .pad_out    (port7_out[gi]),
        .pad_oe     (port7_oe[gi])
      );
      pin_cell u_p8 (
        .periph_sel (p8_sel[gi]),
        .periph_val (p8_val[gi]),
        .port_val   (p8_data_ff[gi]),
        .port_dir   (p8_dir_ff[gi]),
        .open_drain (1'b0),
        .pad_out    (port8_out[gi]),
        .pad_oe     (port8_oe[gi])
      );
      pin_cell u_p9 (
        .periph_sel (1'b0),
        .periph_val (1'b0),
        .port_val   (p9_data_ff[gi]),
        .port_dir   (1'b0),
        .open_drain (1'b1),
        .pad_out    (p9_o[gi]),
        .pad_oe     (p9_e[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Checks on port five
  rd_strobe_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    extbus_ff |-> (port5_oe[0] && port5_out[0] == ext_read_strobe))
    else $error("strobe lost");
  single_chip_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !extbus_ff |-> (port5_out[0] == p5_data_ff[0] && port5_oe[0] == p5_dir_ff[0]))
    else $error("p5 bit6 not port");
  inhibit_in_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ram_write_inhibit_req == port5_in[1] && port5_out[1] == p5_data_ff[1]
      && port5_oe[1] == p5_dir_ff[1])
    else $error("inhibit pin not plain port");

  // ==========================================================
  // Checks on ports six and nine
  od_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port6_out == 8'h00) && (port9_out == 8'h00))
    else $error("open drain drives high");
  od_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((port6_oe | analog_en_ff[7:0]) == (~p6_data_ff | analog_en_ff[7:0]))
      && ((port9_oe | analog_en_ff[15:8]) == (~p9_data_ff | analog_en_ff[15:8])))
    else $error("open drain enable wrong");
  analog_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((port6_oe & analog_en_ff[7:0]) == 8'h00)
      && ((port9_oe & analog_en_ff[15:8]) == 8'h00))
    else $error("analog pin driven");
  analog_route_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((analog_channel_low_group & analog_en_ff[7:0]) == (port6_in & analog_en_ff[7:0]))
      && ((analog_channel_high_group & analog_en_ff[15:8]) == (port9_in & analog_en_ff[15:8])))
    else $error("analog channel not routed");

  // ==========================================================
  // Checks on port seven
  compare_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    periph_en_ff[`PEN_COMPARE_BIT] |-> (port7_out == compare_unit_outputs && port7_oe == 8'hff))
    else $error("compare out lost");
  port_data_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !periph_en_ff[`PEN_COMPARE_BIT] |-> (port7_out == p7_data_ff && port7_oe == p7_dir_ff))
    else $error("port data lost");

  // ==========================================================
  // Checks on port eight
  timer_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port8_out[5:0] & periph_en_ff[6:1]) == (reload_timer_outputs & periph_en_ff[6:1]))
    else $error("timer out lost");
  timer_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port8_oe[5:0] & periph_en_ff[6:1]) == periph_en_ff[6:1])
    else $error("timer pin not driven");
  timer_port_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port8_out[5:0] & ~periph_en_ff[6:1]) == (p8_data_ff[5:0] & ~periph_en_ff[6:1]))
    else $error("timer pin not port");
  pulse_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    periph_en_ff[`PEN_PULSE_BIT] |-> (port8_out[7:6] == {pulse_gen_out_b, pulse_gen_out_a}))
    else $error("pulse out lost");
  pulse_port_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !periph_en_ff[`PEN_PULSE_BIT] |-> (port8_out[7:6] == p8_data_ff[7:6]))
    else $error("pulse pin not port");

  // ==========================================================
  // Scenario covers
  ext_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(extbus_ff));
  cmp_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(periph_en_ff[0]));
  an_cov_c:  cover property (@(posedge clk_sys) disable iff (!resetn) analog_en_ff != 16'h0);
  tmr_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) periph_en_ff[6:1] != 6'h0);
  pls_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    periph_en_ff[7] && pulse_gen_out_b);
endmodule : port_pin_function_select
`default_nettype wire
